// >>> rtl/protect_pkg.sv
// Shared constants and types for the supply protection sequencer.
package protect_pkg;

    // Timing of the dynamic overload cycle, in milliseconds and in cycles.
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned ON_WINDOW_MS  = 90;
    localparam int unsigned OFF_WINDOW_MS = 900;
    localparam int unsigned PERIOD_MS     = ON_WINDOW_MS + OFF_WINDOW_MS;
    localparam int unsigned ON_WINDOW_CYC  = ON_WINDOW_MS * CLK_PER_MS;
    localparam int unsigned OFF_WINDOW_CYC = OFF_WINDOW_MS * CLK_PER_MS;
    localparam int unsigned TIMER_W        = 32;

    // Sections, output level field and its reset value.
    localparam int unsigned SECTIONS  = 2;
    localparam int unsigned LEVEL_W   = 4;
    localparam logic [3:0]  LEVEL_OFF = 4'h0;

    // Converter compensation encodings.
    localparam logic COMP_ELECTROLYTIC = 1'b0;
    localparam logic COMP_CERAMIC      = 1'b1;

    // Slave address width and defaults; the address values are arbitrary.
    localparam int unsigned ADDR_W         = 7;
    localparam logic [6:0]  ADDR_LOW_DEF   = 7'h10;
    localparam logic [6:0]  ADDR_HIGH_DEF  = 7'h11;

    // Positions of the pin inputs inside the synchroniser vector.
    localparam int unsigned SYNC_W    = 5;
    localparam int unsigned SYNC_OL0  = 0;
    localparam int unsigned SYNC_HEAT = 2;
    localparam int unsigned SYNC_ADDR = 3;
    localparam int unsigned SYNC_READ = 4;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ON   = 3'b010,
        SEQ_OFF  = 3'b100
    } seq_state_type;

endpackage

// >>> rtl/overload_sequencer.sv
// Dynamic on/off overload timer for one supply section.
`timescale 1ns/100ps
`default_nettype none
module overload_sequencer #(
    parameter int unsigned ON_CYC  = protect_pkg::ON_WINDOW_CYC,
    parameter int unsigned OFF_CYC = protect_pkg::OFF_WINDOW_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic overload,
    input  wire logic pulsedLimitSel,
    output logic      supplyOn,
    output logic      tripPulse,
    output logic      causeActive
);
    import protect_pkg::*;

    typedef struct packed {
        seq_state_type        state;
        logic [TIMER_W-1:0]   cnt;
        logic                 seen;
    } seq_type;

    seq_type q_q;
    seq_type q_d;
    logic    onEnd;
    logic    offEnd;

    assign onEnd  = q_q.cnt == TIMER_W'(ON_CYC - 1);
    assign offEnd = q_q.cnt == TIMER_W'(OFF_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        q_d       = q_q;
        tripPulse = 1'b0;
        case (q_q.state)
            SEQ_IDLE: begin
                if (overload) begin
                    q_d.state = SEQ_ON;
                    q_d.cnt   = '0;
                    q_d.seen  = 1'b1;
                end
            end
            SEQ_ON: begin
                q_d.cnt = q_q.cnt + TIMER_W'(1);
                if (overload) begin
                    q_d.seen = 1'b1;
                end
                if (onEnd) begin
                    q_d.cnt  = '0;
                    q_d.seen = 1'b0;
                    if (q_q.seen || overload) begin
                        q_d.state = SEQ_OFF;
                        tripPulse = 1'b1;
                    end else begin
                        q_d.state = SEQ_IDLE;
                    end
                end
            end
            SEQ_OFF: begin
                q_d.cnt = q_q.cnt + TIMER_W'(1);
                if (offEnd) begin
                    q_d.state = SEQ_ON;
                    q_d.cnt   = '0;
                    q_d.seen  = 1'b0;
                end
            end
            default: begin
                q_d.state = SEQ_IDLE;
            end
        endcase
        // A static clamp never cycles; leaving dynamic mode aborts a cycle.
        if (pulsedLimitSel) begin
            q_d.state = SEQ_IDLE;
            q_d.cnt   = '0;
            q_d.seen  = 1'b0;
            tripPulse = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_q <= '{state: SEQ_IDLE, cnt: '0, seen: 1'b0};
        end else begin
            q_q <= q_d;
        end
    end

    assign supplyOn    = q_q.state != SEQ_OFF;
    assign causeActive = overload || (q_q.state != SEQ_IDLE);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_tripOff;
        tripPulse |=> q_q.state == SEQ_OFF && !supplyOn;
    endproperty
    a_tripOff: assert property (p_tripOff)
        else $error("Trip did not shut the section down.");

    property p_offResume;
        q_q.state == SEQ_OFF && offEnd && !pulsedLimitSel
            |=> q_q.state == SEQ_ON && supplyOn && q_q.cnt == '0;
    endproperty
    a_offResume: assert property (p_offResume)
        else $error("Off window end did not resume the output.");

    property p_cleanEnd;
        q_q.state == SEQ_ON && onEnd && !q_q.seen && !overload
            && !pulsedLimitSel |=> q_q.state == SEQ_IDLE;
    endproperty
    a_cleanEnd: assert property (p_cleanEnd)
        else $error("Clean on window did not return to normal.");

    property p_staticNoCycle;
        pulsedLimitSel |=> q_q.state == SEQ_IDLE && supplyOn;
    endproperty
    a_staticNoCycle: assert property (p_staticNoCycle)
        else $error("Static clamp mode entered the pulsed cycle.");

    property p_periodBound;
        (q_q.state == SEQ_OFF |-> q_q.cnt < TIMER_W'(OFF_CYC))
        and (q_q.state == SEQ_ON |-> q_q.cnt < TIMER_W'(ON_CYC));
    endproperty
    a_periodBound: assert property (p_periodBound)
        else $error("Window timer ran past its length.");

endmodule
`default_nettype wire

// >>> rtl/supply_protection_sequencer.sv
// Overload and overheat protection control for a dual supply regulator.
//
// Function
// - Compensation select bit: 0 electrolytic, 1 ceramic output capacitors.
// - Per-section select: low gives pulsed protection, high a static clamp.
// - Pulsed mode keeps output on 90 ms after overload, then off 900 ms.
// - The pulsed shutdown sets that section's overload flag.
// - After the off window output resumes; repeats while overload persists.
// - A clean on window restores normal operation; flag clears after a read.
// - On plus off period comes from an internal timer, about 990 ms.
// - Clamp mode sets the flag at the limit; clears after end and read.
// - Overload restart policy 1 clears section levels, output stays off.
// - Overload restart policy 0 re-enables output when overload ends.
// - Overheat stops converter and both outputs and sets the overheat flag.
// - Heat restart policy 1 clears both sections' levels to zero.
// - Heat restart policy 0 re-enables outputs when overheat ends.
// - Slave address is one of two, chosen by the address select pin.
// - Every flag stays set until cause is gone and a fresh read occurs.
// - Under lockout all control bits are zero and outputs are disabled.
`timescale 1ns/100ps
`default_nettype none
module supply_protection_sequencer #(
    parameter int unsigned ON_CYC     = protect_pkg::ON_WINDOW_CYC,
    parameter int unsigned OFF_CYC    = protect_pkg::OFF_WINDOW_CYC,
    parameter logic [6:0]  ADDR_LOW   = protect_pkg::ADDR_LOW_DEF,
    parameter logic [6:0]  ADDR_HIGH  = protect_pkg::ADDR_HIGH_DEF
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic                            compSelect,
    input  wire logic [protect_pkg::SECTIONS-1:0] pulsedLimitSel,
    input  wire logic                            overloadRestartPolicy,
    input  wire logic                            heatRestartPolicy,
    input  wire logic [protect_pkg::SECTIONS-1:0] levelWrite,
    input  wire logic [protect_pkg::LEVEL_W-1:0]  levelWriteData,
    input  wire logic [protect_pkg::SECTIONS-1:0] overloadDetect,
    input  wire logic                            overheatDetect,
    input  wire logic                            addrSelPin,
    input  wire logic                            statusReadToggle,
    output logic [protect_pkg::SECTIONS-1:0][protect_pkg::LEVEL_W-1:0]
                                                 outputLevelBits,
    output logic [protect_pkg::SECTIONS-1:0]     sectionSupplyOut,
    output logic                                 boostEnable,
    output logic                                 compSelectOut,
    output logic [protect_pkg::SECTIONS-1:0]     overloadFlag,
    output logic                                 overheatFlag,
    output logic [protect_pkg::ADDR_W-1:0]       slaveAddr
);
    import protect_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0]                   meta;
        logic [SYNC_W-1:0]                   sync;
        logic                                readPrev;
        logic [SECTIONS-1:0][LEVEL_W-1:0]    level;
        logic [SECTIONS-1:0]                 olFlag;
        logic                                heatFlag;
        logic [SECTIONS-1:0]                 secEn;
        logic                                boostEn;
        logic                                comp;
        logic [ADDR_W-1:0]                   addr;
    } ctrl_type;

    ctrl_type            ctrl_q;
    ctrl_type            ctrl_d;
    logic [SYNC_W-1:0]   rawPins;
    logic                readDone;
    logic                heat;
    logic [SECTIONS-1:0] olSync;
    logic [SECTIONS-1:0] trip;
    logic [SECTIONS-1:0] supplyOn;
    logic [SECTIONS-1:0] cause;
    logic [SECTIONS-1:0] setEvent;

    ////////////////////////////////////////////////////////////////////////
    // Every pin and the read-done toggle from the serial side pass two
    // flip-flops; only the second stage is read by any logic.
    assign rawPins  = {statusReadToggle, addrSelPin, overheatDetect,
                       overloadDetect};
    assign readDone = ctrl_q.sync[SYNC_READ] ^ ctrl_q.readPrev;
    assign heat     = ctrl_q.sync[SYNC_HEAT];
    assign olSync   = ctrl_q.sync[SYNC_OL0 +: SECTIONS];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < SECTIONS; g = g + 1) begin : gen_sec
            overload_sequencer #(
                .ON_CYC  (ON_CYC),
                .OFF_CYC (OFF_CYC)
            ) u_seq (
                .sys_clk        (sys_clk),
                .rst            (rst),
                .overload       (olSync[g]),
                .pulsedLimitSel (pulsedLimitSel[g]),
                .supplyOn       (supplyOn[g]),
                .tripPulse      (trip[g]),
                .causeActive    (cause[g])
            );

            // Clamp mode flags on the limit itself, pulsed mode on the trip.
            assign setEvent[g] = pulsedLimitSel[g] ? olSync[g] : trip[g];

            property p_flagSet;
                @(posedge sys_clk) disable iff (rst)
                setEvent[g] |=> overloadFlag[g];
            endproperty
            a_flagSet: assert property (p_flagSet)
                else $error("Overload event did not set its flag.");

            property p_flagHold;
                @(posedge sys_clk) disable iff (rst)
                overloadFlag[g] && !(readDone && !cause[g])
                    |=> overloadFlag[g];
            endproperty
            a_flagHold: assert property (p_flagHold)
                else $error("Overload flag dropped without a clean read.");

            property p_restartClear;
                @(posedge sys_clk) disable iff (rst)
                setEvent[g] && overloadRestartPolicy
                    |=> (outputLevelBits[g] == LEVEL_OFF
                        && !sectionSupplyOut[g]) [*2];
            endproperty
            a_restartClear: assert property (p_restartClear)
                else $error("Latched restart left the section enabled.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        ctrl_d          = ctrl_q;
        ctrl_d.meta     = rawPins;
        ctrl_d.sync     = ctrl_q.meta;
        ctrl_d.readPrev = ctrl_q.sync[SYNC_READ];
        for (int i = 0; i < int'(SECTIONS); i++) begin
            if (levelWrite[i]) begin
                ctrl_d.level[i] = levelWriteData;
            end
            // Device clears win over a host write in the same cycle.
            if (setEvent[i] && overloadRestartPolicy) begin
                ctrl_d.level[i] = LEVEL_OFF;
            end
            if (heat && heatRestartPolicy) begin
                ctrl_d.level[i] = LEVEL_OFF;
            end
            // The read completes before the clear; a new event wins.
            if (readDone && !cause[i]) begin
                ctrl_d.olFlag[i] = 1'b0;
            end
            if (setEvent[i]) begin
                ctrl_d.olFlag[i] = 1'b1;
            end
            // With policy 0 the levels survive and the output returns alone.
            ctrl_d.secEn[i] = supplyOn[i] && !heat
                              && (ctrl_d.level[i] != LEVEL_OFF);
        end
        if (readDone && !heat) begin
            ctrl_d.heatFlag = 1'b0;
        end
        if (heat) begin
            ctrl_d.heatFlag = 1'b1;
        end
        ctrl_d.boostEn = !heat;
        ctrl_d.comp    = compSelect;
        ctrl_d.addr    = ctrl_q.sync[SYNC_ADDR] ? ADDR_HIGH : ADDR_LOW;
    end

    // Reset stands for power-on and lockout: every control bit is zero.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign outputLevelBits  = ctrl_q.level;
    assign sectionSupplyOut = ctrl_q.secEn;
    assign boostEnable      = ctrl_q.boostEn;
    assign compSelectOut    = ctrl_q.comp;
    assign overloadFlag     = ctrl_q.olFlag;
    assign overheatFlag     = ctrl_q.heatFlag;
    assign slaveAddr        = ctrl_q.addr;

    ////////////////////////////////////////////////////////////////////////
    property p_heatOff;
        @(posedge sys_clk) disable iff (rst)
        heat |=> !boostEnable && sectionSupplyOut == '0 && overheatFlag;
    endproperty
    a_heatOff: assert property (p_heatOff)
        else $error("Overheat did not stop converter and outputs.");

    property p_heatClear;
        @(posedge sys_clk) disable iff (rst)
        heat && heatRestartPolicy |=> outputLevelBits == '0;
    endproperty
    a_heatClear: assert property (p_heatClear)
        else $error("Heat restart policy did not clear the levels.");

    property p_heatRead;
        @(posedge sys_clk) disable iff (rst)
        overheatFlag && readDone && !heat |=> !overheatFlag;
    endproperty
    a_heatRead: assert property (p_heatRead)
        else $error("Clean read did not clear the overheat flag.");

    property p_compSel;
        @(posedge sys_clk) disable iff (rst)
        compSelect ##1 compSelect |=> compSelectOut == COMP_CERAMIC;
    endproperty
    a_compSel: assert property (p_compSel)
        else $error("Compensation select not applied.");

    property p_addrSel;
        @(posedge sys_clk) disable iff (rst)
        addrSelPin [*4] |-> slaveAddr == ADDR_HIGH;
    endproperty
    a_addrSel: assert property (p_addrSel)
        else $error("Address pin high did not select the upper address.");

endmodule
`default_nettype wire

// >>> tb/host_model.sv
// Host controller model: level writes, mode selects and status reads.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic                             sys_clk,
    output logic [protect_pkg::SECTIONS-1:0]      levelWrite,
    output logic [protect_pkg::LEVEL_W-1:0]       levelWriteData,
    output logic [protect_pkg::SECTIONS-1:0]      pulsedLimitSel,
    output logic                                  statusReadToggle
);
    import protect_pkg::*;

    initial begin
        levelWrite = 2'h0;
        levelWriteData = 4'h0;
        pulsedLimitSel = 2'h3;
        statusReadToggle = 1'b0;
    end

    // A latched stop is only undone by writing the level again.
    task automatic write_level(input int sec, input logic [3:0] val);
        @(posedge sys_clk);
        #1;
        levelWrite[sec] = 1'b1;
        levelWriteData = val;
        @(posedge sys_clk);
        #1;
        levelWrite = 2'h0;
    endtask

    task automatic set_mode(input logic [1:0] sel);
        @(posedge sys_clk);
        #1;
        pulsedLimitSel = sel;
    endtask

    // A read frame lasts two 80 ns link periods; the toggle marks the
    // completed read, and the frame time keeps reads well apart.
    task automatic status_read;
        #1;
        statusReadToggle = ~statusReadToggle;
        #159;
    endtask
endmodule
`default_nettype wire

// >>> tb/supply_protection_sequencer_test.sv
// Self-checking bench for the supply protection sequencer.
`timescale 1ns/100ps
`default_nettype none
module supply_protection_sequencer_test;
    import protect_pkg::*;

    logic                              sys_clk;
    logic                              rst;
    logic                              compSelect;
    logic [SECTIONS-1:0]               pulsedLimitSel;
    logic                              overloadRestartPolicy;
    logic                              heatRestartPolicy;
    logic [SECTIONS-1:0]               levelWrite;
    logic [LEVEL_W-1:0]                levelWriteData;
    logic [SECTIONS-1:0]               overloadDetect;
    logic                              overheatDetect;
    logic                              addrSelPin;
    logic                              statusReadToggle;
    logic [SECTIONS-1:0][LEVEL_W-1:0]  outputLevelBits;
    logic [SECTIONS-1:0]               sectionSupplyOut;
    logic                              boostEnable;
    logic                              compSelectOut;
    logic [SECTIONS-1:0]               overloadFlag;
    logic                              overheatFlag;
    logic [ADDR_W-1:0]                 slaveAddr;
    int                                errTotal;
    int                                testsRun;

    supply_protection_sequencer #(.ON_CYC(20), .OFF_CYC(50)) dut (
        .sys_clk(sys_clk), .rst(rst), .compSelect(compSelect),
        .pulsedLimitSel(pulsedLimitSel),
        .overloadRestartPolicy(overloadRestartPolicy),
        .heatRestartPolicy(heatRestartPolicy), .levelWrite(levelWrite),
        .levelWriteData(levelWriteData), .overloadDetect(overloadDetect),
        .overheatDetect(overheatDetect), .addrSelPin(addrSelPin),
        .statusReadToggle(statusReadToggle),
        .outputLevelBits(outputLevelBits),
        .sectionSupplyOut(sectionSupplyOut), .boostEnable(boostEnable),
        .compSelectOut(compSelectOut), .overloadFlag(overloadFlag),
        .overheatFlag(overheatFlag), .slaveAddr(slaveAddr));

    host_model host (
        .sys_clk(sys_clk), .levelWrite(levelWrite),
        .levelWriteData(levelWriteData), .pulsedLimitSel(pulsedLimitSel),
        .statusReadToggle(statusReadToggle));

    always #5 sys_clk = ~sys_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        testsRun++;
        if (seen !== want) begin
            errTotal++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic results;
        $display("checks=%0d mismatches=%0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Worst case is well under a thousand cycles; this leaves wide margin.
    initial begin
        #50000;
        errTotal++;
        results();
    end

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        compSelect = 1'b0;
        overloadRestartPolicy = 1'b0;
        heatRestartPolicy = 1'b0;
        overloadDetect = 2'h0;
        overheatDetect = 1'b0;
        addrSelPin = 1'b0;
        errTotal = 0;
        testsRun = 0;
        tick(4);
        check(8'(outputLevelBits), 8'h00);
        check(8'({overloadFlag, overheatFlag, sectionSupplyOut}), 8'h00);
        rst = 1'b0;
        tick(5);
        check(8'(slaveAddr), 8'h10);
        check(8'(boostEnable), 8'h01);
        addrSelPin = 1'b1;
        tick(5);
        check(8'(slaveAddr), 8'h11);
        for (int i = 0; i < 2; i++) begin
            compSelect = i[0];
            tick(3);
            check(8'(compSelectOut), 8'(i));
        end
        host.write_level(0, 4'h5);
        host.write_level(1, 4'hA);
        tick(1);
        check(8'(outputLevelBits), 8'hA5);
        check(8'(sectionSupplyOut), 8'h03);
        // Static clamp on section A, automatic restart.
        overloadDetect[0] = 1'b1;
        tick(5);
        check(8'(overloadFlag), 8'h01);
        tick(30);
        check(8'(sectionSupplyOut), 8'h03);
        host.status_read();
        tick(3);
        check(8'(overloadFlag), 8'h01);
        overloadDetect[0] = 1'b0;
        tick(5);
        check(8'(sectionSupplyOut), 8'h03);
        check(8'(outputLevelBits), 8'hA5);
        check(8'(overloadFlag), 8'h01);
        host.status_read();
        tick(3);
        check(8'(overloadFlag), 8'h00);
        // Static clamp with latched restart.
        overloadRestartPolicy = 1'b1;
        overloadDetect[0] = 1'b1;
        tick(5);
        check(8'(outputLevelBits), 8'hA0);
        overloadDetect[0] = 1'b0;
        tick(5);
        check(8'(sectionSupplyOut), 8'h02);
        host.write_level(0, 4'h7);
        tick(1);
        check(8'(outputLevelBits), 8'hA7);
        check(8'(sectionSupplyOut), 8'h03);
        host.status_read();
        tick(3);
        check(8'(overloadFlag), 8'h00);
        overloadRestartPolicy = 1'b0;
        // Pulsed protection on section B, tripping twice.
        host.set_mode(2'b01);
        overloadDetect[1] = 1'b1;
        tick(12);
        check(8'({overloadFlag[1], sectionSupplyOut[1]}), 8'h01);
        tick(15);
        check(8'({overloadFlag[1], sectionSupplyOut[1]}), 8'h02);
        host.status_read();
        tick(2);
        check(8'(overloadFlag), 8'h02);
        tick(20);
        check(8'(sectionSupplyOut), 8'h01);
        tick(15);
        check(8'(sectionSupplyOut), 8'h03);
        tick(20);
        check(8'(sectionSupplyOut), 8'h01);
        overloadDetect[1] = 1'b0;
        tick(80);
        check(8'(sectionSupplyOut), 8'h03);
        check(8'(overloadFlag), 8'h02);
        host.status_read();
        tick(3);
        check(8'(overloadFlag), 8'h00);
        check(8'(outputLevelBits), 8'hA7);
        // Overheat with automatic, then latched restart.
        overheatDetect = 1'b1;
        tick(5);
        check(8'({overheatFlag, boostEnable, sectionSupplyOut}), 8'h08);
        overheatDetect = 1'b0;
        tick(5);
        check(8'({overheatFlag, boostEnable, sectionSupplyOut}), 8'h0F);
        host.status_read();
        tick(3);
        check(8'(overheatFlag), 8'h00);
        heatRestartPolicy = 1'b1;
        overheatDetect = 1'b1;
        tick(5);
        check(8'(outputLevelBits), 8'h00);
        overheatDetect = 1'b0;
        tick(5);
        check(8'(sectionSupplyOut), 8'h00);
        host.write_level(0, 4'h3);
        host.write_level(1, 4'h4);
        tick(1);
        check(8'(outputLevelBits), 8'h43);
        host.status_read();
        tick(3);
        check(8'(overheatFlag), 8'h00);
        // A lockout in mid-run clears all control state.
        rst = 1'b1;
        tick(4);
        check(8'(outputLevelBits), 8'h00);
        check(8'({overloadFlag, overheatFlag, compSelectOut}), 8'h00);
        rst = 1'b0;
        tick(3);
        check(8'(slaveAddr), 8'(ADDR_HIGH_DEF));
        check(8'({boostEnable, compSelectOut}), 8'h03);
        results();
    end
endmodule
`default_nettype wire
